// ==== core/ssf_top.sv ====
// Summary of operation
// [RQ1] Paging: byte 3 set only on op incomplete; 06 read, 05 write.
// [RQ2] Caching formats 1,2,6,7,8: byte 3 holds controller identity.
// [RQ3] Caching formats 0,3,4,5,F: byte 3 zero, or residual count if imprecise.
// [RQ4] Paging direct or listed formats: byte 4 one-hot device in bits 0-3.
// [RQ5] Paging address with formats 0,3, F msgs 0-5,8: byte 4 zero.
// [RQ6] Caching byte 4: dual path, zeros, spindle 4-2-1, actuator side.
// [RQ7] Caching byte 4 bit 2 flags permanent path error in format 7 only.
// [RQ8] Caching storage error: byte 4 names device addressed by the chain.
// [RQ9] Format 3 not message 8: byte 5 is captured address high byte.
// [RQ10] Format 6: byte 5 holds comm failure and diskette seek/read counts.
// [RQ11] Seek formats: byte 5 is low cylinder byte of latest seek.
// [RQ12] Paging byte 6: service cylinder, cyl 512, cyl 256, head address.
// [RQ13] Caching byte 6: unused, high cylinder bits 5-7, head address.
// [RQ14] Head switches update only the head bits of byte 6.
// [RQ15] Alternate track during overflow with op incomplete reports head+1.
// [RQ16] Paging direct mode ignores rejected seek head and high cylinder.
// [RQ17] Format 3 not message 8: byte 6 is captured address low byte.
// [RQ18] Format 6: byte 6 holds storage director identity.
// [RQ19] Paging format F messages 3 or 4: byte 6 holds storage identifier.
// [RQ20] Byte 7 holds format in bits 0-3, message in bits 4-7.
// [RQ21] Imprecise flag set on abnormal end for earlier completed command.
// [RQ22] Bytes 3-6 freeze at unit check until host reads them.
`timescale 1ns/1ps
`default_nettype none
module ssf_top
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        unit_check,
    input  wire logic [7:0]  sense_fmt_msg,
    input  wire logic        op_incomplete,
    input  wire logic        op_write,
    input  wire logic        abnormal_end,
    input  wire logic        exc_prev_ccw,
    input  wire logic [7:0]  residual_count,
    input  wire logic [7:0]  controller_id,
    input  wire logic [15:0] iar,
    input  wire logic [1:0]  device_num,
    input  wire logic [2:0]  spindle,
    input  wire logic        actuator_right,
    input  wire logic        perm_path_err,
    input  wire logic        storage_err,
    input  wire logic [2:0]  chain_spindle,
    input  wire logic        chain_actuator_right,
    input  wire logic        seek_stb,
    input  wire logic        seek_rej,
    input  wire logic [7:0]  seek_cyl_hi,
    input  wire logic [7:0]  seek_cyl_lo,
    input  wire logic        seek_service,
    input  wire logic [4:0]  seek_head,
    input  wire logic        hs_stb,
    input  wire logic [4:0]  hs_head,
    input  wire logic        alt_ovf_stb,
    input  wire logic        iml_start,
    input  wire logic        comm_fail_evt,
    input  wire logic        dsk_seek_err,
    input  wire logic        dsk_read_err,
    output logic             sense_pending
);
    localparam int CW = ssf_pkg::DSK_CNT_W;

    logic [31:0]   ctrl;
    logic [7:0]    b3;
    logic [7:0]    b4;
    logic [7:0]    b5;
    logic [7:0]    b6;
    logic [7:0]    b7;
    logic          frozen;
    logic          imprecise;
    logic          comm_fail;
    logic [CW-1:0] dsk_seek_cnt;
    logic [CW-1:0] dsk_read_cnt;

    ssf_cap_if cif();

    ssf_capture u_capture
    (
        .clk (clk),
        .rst (rst),
        .cif (cif)
    );

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    wire       caching   = ctrl[ssf_pkg::CTRL_CACHING];
    wire       pag_addr  = ctrl[ssf_pkg::CTRL_PAG_ADDR];
    wire       dual_path = ctrl[ssf_pkg::CTRL_DUALPATH];
    wire [7:0] dir_id    = ctrl[ssf_pkg::CTRL_DIR_LSB +: 8];
    wire [7:0] stor_id   = ctrl[ssf_pkg::CTRL_STOR_LSB +: 8];

    assign cif.caching       = caching;
    assign cif.direct_mode   = ~pag_addr;
    assign cif.op_incomplete = op_incomplete;
    assign cif.seek_stb      = seek_stb;
    assign cif.seek_rej      = seek_rej;
    assign cif.seek_cyl_hi   = seek_cyl_hi;
    assign cif.seek_cyl_lo   = seek_cyl_lo;
    assign cif.seek_service  = seek_service;
    assign cif.seek_head     = seek_head;
    assign cif.hs_stb        = hs_stb;
    assign cif.hs_head       = hs_head;
    assign cif.alt_ovf_stb   = alt_ovf_stb;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire acc      = psel & penable & ~pready;
    wire done     = psel & penable & pready;
    wire hit_ctrl = paddr == ssf_pkg::ADDR_CTRL;
    wire hit_s36  = paddr == ssf_pkg::ADDR_SENSE36;
    wire hit_s7   = paddr == ssf_pkg::ADDR_SENSE7;
    wire hit_stat = paddr == ssf_pkg::ADDR_STATUS;
    wire mapped   = hit_ctrl | hit_s36 | hit_s7 | hit_stat;
    wire wr_ctrl  = done & pwrite & hit_ctrl;
    wire sense_rd = done & ~pwrite & hit_s36;
    wire take     = unit_check & (~frozen | sense_rd); // RQ22

    wire [31:0] status_word =
        {17'h0, dsk_read_cnt, 1'b0, dsk_seek_cnt, 5'h00,
         comm_fail, imprecise, frozen};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl :
        hit_s36  ? {b3, b4, b5, b6} :
        hit_s7   ? {24'h0, b7} :
        hit_stat ? status_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Format decode
    // ------------------------------------------------------------
    wire [3:0] fmt = sense_fmt_msg[7:4]; // RQ20
    wire [3:0] msg = sense_fmt_msg[3:0]; // RQ20

    wire f_ctlid  = fmt == ssf_pkg::FMT_1 || fmt == ssf_pkg::FMT_2 ||
                    fmt == ssf_pkg::FMT_6 || fmt == ssf_pkg::FMT_7 ||
                    fmt == ssf_pkg::FMT_8;
    wire f_resid  = fmt == ssf_pkg::FMT_0 || fmt == ssf_pkg::FMT_3 ||
                    fmt == ssf_pkg::FMT_4 || fmt == ssf_pkg::FMT_5 ||
                    fmt == ssf_pkg::FMT_F;
    wire f_devsel = fmt == ssf_pkg::FMT_1 || fmt == ssf_pkg::FMT_2 ||
                    fmt == ssf_pkg::FMT_4 || fmt == ssf_pkg::FMT_5 ||
                    (fmt == ssf_pkg::FMT_F && msg == ssf_pkg::MSG_7);
    wire f_iar    = fmt == ssf_pkg::FMT_3 && msg != ssf_pkg::MSG_8;
    wire f_dsk    = fmt == ssf_pkg::FMT_6;
    wire f_seek_b = fmt == ssf_pkg::FMT_0 || fmt == ssf_pkg::FMT_1 ||
                    fmt == ssf_pkg::FMT_2 || fmt == ssf_pkg::FMT_4 ||
                    fmt == ssf_pkg::FMT_5 || fmt == ssf_pkg::FMT_F ||
                    sense_fmt_msg == ssf_pkg::BYTE7_SEEK;
    wire f_seek_c = fmt == ssf_pkg::FMT_7 || fmt == ssf_pkg::FMT_8;
    wire f_seek   = f_seek_b | (caching & f_seek_c); // RQ11
    wire f_stor   = ~caching & fmt == ssf_pkg::FMT_F &
                    (msg == ssf_pkg::MSG_3 || msg == ssf_pkg::MSG_4);

    // ------------------------------------------------------------
    // Byte 3
    // ------------------------------------------------------------
    wire [7:0] b3_pag = !op_incomplete ? ssf_pkg::BYTE_ZERO :
                        op_write ? ssf_pkg::RESTART_WRITE :
                        ssf_pkg::RESTART_READ; // RQ1
    wire [7:0] b3_cac = f_ctlid ? controller_id : // RQ2
                        (f_resid && imprecise) ? residual_count :
                        ssf_pkg::BYTE_ZERO; // RQ3
    wire [7:0] next_b3 = caching ? b3_cac : b3_pag;

    // ------------------------------------------------------------
    // Byte 4
    // ------------------------------------------------------------
    wire [7:0] b4_pag = (!pag_addr || f_devsel) ?
                        ssf_pkg::DEV_ONEHOT0 >> device_num : // RQ4
                        ssf_pkg::BYTE_ZERO; // RQ5
    wire [2:0] dev_spin = storage_err ? chain_spindle : spindle; // RQ8
    wire       dev_act  = storage_err ? chain_actuator_right :
                          actuator_right; // RQ8
    wire       perm_bit = perm_path_err & (fmt == ssf_pkg::FMT_7); // RQ7
    wire [7:0] b4_cac = {dual_path, 1'b0, perm_bit, 1'b0,
                         dev_spin, dev_act}; // RQ6
    wire [7:0] next_b4 = caching ? b4_cac : b4_pag;

    // ------------------------------------------------------------
    // Bytes 5 and 6
    // ------------------------------------------------------------
    wire [7:0] dsk_byte = {comm_fail, 1'b0, dsk_seek_cnt,
                           dsk_read_cnt}; // RQ10
    wire [7:0] next_b5 = f_iar  ? iar[15:8] : // RQ9
                         f_dsk  ? dsk_byte :
                         f_seek ? cif.cyl_lo : // RQ11
                         ssf_pkg::BYTE_ZERO;

    wire [7:0] chs_pag = {cif.service, cif.cyl_hi[1:0],
                          cif.head_rpt}; // RQ12
    wire [7:0] chs_cac = {1'b0, cif.cyl_hi[2:0],
                          cif.head_rpt[3:0]}; // RQ13
    wire [7:0] next_b6 = f_iar  ? iar[7:0] : // RQ17
                         f_dsk  ? dir_id : // RQ18
                         f_stor ? stor_id : // RQ19
                         f_seek ? (caching ? chs_cac : chs_pag) :
                         ssf_pkg::BYTE_ZERO;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl <= ssf_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= pwdata;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Snapshot at unit check, held until the host reads it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            b3 <= 8'h00;
            b4 <= 8'h00;
            b5 <= 8'h00;
            b6 <= 8'h00;
            b7 <= 8'h00;
        end
        else if (take) // RQ22
        begin
            b3 <= next_b3;
            b4 <= next_b4;
            b5 <= next_b5;
            b6 <= next_b6;
            b7 <= sense_fmt_msg; // RQ20
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            frozen <= 1'b0;
        else if (unit_check)
            frozen <= 1'b1; // RQ22
        else if (sense_rd)
            frozen <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            imprecise <= 1'b0;
        else if (abnormal_end && exc_prev_ccw)
            imprecise <= 1'b1; // RQ21
        else if (sense_rd)
            imprecise <= 1'b0;
    end

    // Diskette statistics since the last initial_microcode_load
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            comm_fail    <= 1'b0;
            dsk_seek_cnt <= '0;
            dsk_read_cnt <= '0;
        end
        else
        begin
            if (comm_fail_evt)
                comm_fail <= 1'b1;
            else if (iml_start)
                comm_fail <= 1'b0;
            if (iml_start)
                dsk_seek_cnt <= '0;
            else if (dsk_seek_err && dsk_seek_cnt != '1)
                dsk_seek_cnt <= dsk_seek_cnt + 1'b1; // RQ10
            if (iml_start)
                dsk_read_cnt <= '0;
            else if (dsk_read_err && dsk_read_cnt != '1)
                dsk_read_cnt <= dsk_read_cnt + 1'b1; // RQ10
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sense_pending <= 1'b0;
        else
            sense_pending <= (frozen & ~sense_rd) | unit_check;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_restart;
        @(posedge clk) disable iff (rst)
        (take && !caching && op_incomplete) |=>
            b3 == ($past(op_write) ? ssf_pkg::RESTART_WRITE :
                   ssf_pkg::RESTART_READ);
    endproperty
    a_restart: assert property (p_restart) // RQ1
        else $error("restart code wrong");

    property p_ctl_id;
        @(posedge clk) disable iff (rst)
        (take && caching && f_ctlid) |=> b3 == $past(controller_id);
    endproperty
    a_ctl_id: assert property (p_ctl_id) // RQ2
        else $error("controller identity not reported");

    property p_resid;
        @(posedge clk) disable iff (rst)
        (take && caching && f_resid) |=>
            b3 == ($past(imprecise) ? $past(residual_count) : 8'h00);
    endproperty
    a_resid: assert property (p_resid) // RQ3
        else $error("residual count byte wrong");

    property p_onehot;
        @(posedge clk) disable iff (rst)
        (take && !caching && !pag_addr) |=>
            $onehot(b4[7:4]) && b4[3:0] == 4'h0;
    endproperty
    a_onehot: assert property (p_onehot) // RQ4
        else $error("device byte not one-hot");

    property p_pag_zero;
        @(posedge clk) disable iff (rst)
        (take && !caching && pag_addr &&
         (fmt == ssf_pkg::FMT_0 || fmt == ssf_pkg::FMT_3)) |=> b4 == 8'h00;
    endproperty
    a_pag_zero: assert property (p_pag_zero) // RQ5
        else $error("paging device byte not zero");

    property p_perm;
        @(posedge clk) disable iff (rst)
        (take && caching && fmt != ssf_pkg::FMT_7) |=> !b4[5];
    endproperty
    a_perm: assert property (p_perm) // RQ7
        else $error("path error bit outside format 7");

    property p_iar;
        @(posedge clk) disable iff (rst)
        (take && f_iar) |=> {b5, b6} == $past(iar);
    endproperty
    a_iar: assert property (p_iar) // RQ9
        else $error("instruction address not captured");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        (frozen && !take) |=> $stable({b3, b4, b5, b6});
    endproperty
    a_freeze: assert property (p_freeze) // RQ22
        else $error("frozen sense bytes changed");

    property p_imprec;
        @(posedge clk) disable iff (rst)
        (abnormal_end && exc_prev_ccw) |=> imprecise;
    endproperty
    a_imprec: assert property (p_imprec) // RQ21
        else $error("imprecise flag not held");
endmodule
`default_nettype wire

// ==== core/ssf_pkg.sv ====
package ssf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_SENSE36  = 8'h04;
    localparam logic [7:0]  ADDR_SENSE7   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    localparam int CTRL_CACHING  = 0;
    localparam int CTRL_PAG_ADDR = 1;
    localparam int CTRL_DUALPATH = 2;
    localparam int CTRL_DIR_LSB  = 8;
    localparam int CTRL_STOR_LSB = 16;
    localparam int STAT_FROZEN   = 0;
    localparam int STAT_IMPREC   = 1;
    localparam int STAT_COMMFAIL = 2;
    localparam int STAT_SEEK_LSB = 8;
    localparam int STAT_READ_LSB = 12;

    // ------------------------------------------------------------
    // Sense codes
    // ------------------------------------------------------------
    localparam logic [7:0] RESTART_READ  = 8'h06;
    localparam logic [7:0] RESTART_WRITE = 8'h05;
    localparam logic [7:0] BYTE7_SEEK    = 8'h38;
    localparam logic [7:0] DEV_ONEHOT0   = 8'h80;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    localparam logic [3:0] FMT_0 = 4'h0;
    localparam logic [3:0] FMT_1 = 4'h1;
    localparam logic [3:0] FMT_2 = 4'h2;
    localparam logic [3:0] FMT_3 = 4'h3;
    localparam logic [3:0] FMT_4 = 4'h4;
    localparam logic [3:0] FMT_5 = 4'h5;
    localparam logic [3:0] FMT_6 = 4'h6;
    localparam logic [3:0] FMT_7 = 4'h7;
    localparam logic [3:0] FMT_8 = 4'h8;
    localparam logic [3:0] FMT_F = 4'hF;
    localparam logic [3:0] MSG_3 = 4'h3;
    localparam logic [3:0] MSG_4 = 4'h4;
    localparam logic [3:0] MSG_7 = 4'h7;
    localparam logic [3:0] MSG_8 = 4'h8;

    localparam int DSK_CNT_W = 3;

endpackage

// ==== core/ssf_cap_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ssf_cap_if;
    logic       caching;
    logic       direct_mode;
    logic       op_incomplete;
    logic       seek_stb;
    logic       seek_rej;
    logic [7:0] seek_cyl_hi;
    logic [7:0] seek_cyl_lo;
    logic       seek_service;
    logic [4:0] seek_head;
    logic       hs_stb;
    logic [4:0] hs_head;
    logic       alt_ovf_stb;
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic       service;
    logic [4:0] head_rpt;

    modport drv (output caching, direct_mode, op_incomplete, seek_stb,
                 seek_rej, seek_cyl_hi, seek_cyl_lo, seek_service,
                 seek_head, hs_stb, hs_head, alt_ovf_stb,
                 input cyl_hi, cyl_lo, service, head_rpt);
    modport cap (input caching, direct_mode, op_incomplete, seek_stb,
                 seek_rej, seek_cyl_hi, seek_cyl_lo, seek_service,
                 seek_head, hs_stb, hs_head, alt_ovf_stb,
                 output cyl_hi, cyl_lo, service, head_rpt);
endinterface
`default_nettype wire

// ==== core/ssf_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssf_capture
(
    input  wire logic clk,
    input  wire logic rst,
    ssf_cap_if.cap    cif
);
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic       service;
    logic [4:0] head;
    logic       alt_hit;

    // ------------------------------------------------------------
    // Seek and head tracking
    // ------------------------------------------------------------
    wire keep_old = cif.seek_rej & cif.direct_mode & ~cif.caching; // RQ16

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cyl_hi  <= 8'h00;
            cyl_lo  <= 8'h00;
            service <= 1'b0;
            head    <= 5'h00;
        end
        else if (cif.seek_stb)
        begin
            cyl_lo <= cif.seek_cyl_lo;
            if (!keep_old) // RQ16
            begin
                cyl_hi  <= cif.seek_cyl_hi;
                service <= cif.seek_service;
                head    <= cif.seek_head;
            end
        end
        else if (cif.hs_stb)
        begin
            head <= cif.hs_head; // RQ14
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            alt_hit <= 1'b0;
        else if (cif.alt_ovf_stb)
            alt_hit <= 1'b1;
        else if (cif.seek_stb || cif.hs_stb)
            alt_hit <= 1'b0;
    end

    assign cif.cyl_hi   = cyl_hi;
    assign cif.cyl_lo   = cyl_lo;
    assign cif.service  = service;
    // Defective track head plus one
    assign cif.head_rpt = head + {4'h0, alt_hit & cif.op_incomplete}; // RQ15

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hs_head_only;
        @(posedge clk) disable iff (rst)
        (cif.hs_stb && !cif.seek_stb) |=>
            $stable(cyl_hi) && $stable(service) && head == $past(cif.hs_head);
    endproperty
    a_hs_head_only: assert property (p_hs_head_only) // RQ14
        else $error("head switch touched cylinder fields");

    property p_rej_direct;
        @(posedge clk) disable iff (rst)
        (cif.seek_stb && keep_old) |=> $stable(head) && $stable(cyl_hi);
    endproperty
    a_rej_direct: assert property (p_rej_direct) // RQ16
        else $error("rejected direct seek updated head or cylinder");

    property p_alt_plus1;
        @(posedge clk) disable iff (rst)
        (cif.alt_ovf_stb && !cif.seek_stb && !cif.hs_stb) ##1
            cif.op_incomplete |-> cif.head_rpt == head + 5'h01;
    endproperty
    a_alt_plus1: assert property (p_alt_plus1) // RQ15
        else $error("alternate track head not advanced by one");
endmodule
`default_nettype wire

// ==== verif/ssf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model
(
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'hFF;
        pwdata = 32'hFFFF_FFFF;
    end

    // -----------------------------------------------------------
    // One APB transfer, held until pready is seen at an edge or 50 edges pass
    // -----------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err,
                        output logic done);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'h1;
        done = 1'h0;
        for (n = 0; n < 50 && !done; n++)
        begin
            @(posedge clk);
            done = (pready === 1'h1);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines show inverted junk, not the last value
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/ssf_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssf_top_test;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0]  fm;
        logic [3:0]  flg;
        logic [31:0] exp;
    } ssf_row_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, unit_check;
    logic op_incomplete, op_write, abnormal_end, exc_prev_ccw;
    logic actuator_right, perm_path_err, storage_err, chain_actuator_right;
    logic seek_stb, seek_rej, seek_service, hs_stb, alt_ovf_stb, iml_start;
    logic comm_fail_evt, dsk_seek_err, dsk_read_err, sense_pending, last_err;
    logic [7:0] paddr, sense_fmt_msg, residual_count, controller_id;
    logic [7:0] seek_cyl_hi, seek_cyl_lo;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] iar;
    logic [1:0] device_num;
    logic [2:0] spindle, chain_spindle;
    logic [4:0] seek_head, hs_head;
    int fail_count = 0;
    int compares = 0;
    ssf_row_t rows [11];

    ssf_top ssf_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .unit_check, .sense_fmt_msg,
        .op_incomplete, .op_write, .abnormal_end, .exc_prev_ccw,
        .residual_count, .controller_id, .iar, .device_num, .spindle,
        .actuator_right, .perm_path_err, .storage_err, .chain_spindle,
        .chain_actuator_right, .seek_stb, .seek_rej, .seek_cyl_hi,
        .seek_cyl_lo, .seek_service, .seek_head, .hs_stb, .hs_head,
        .alt_ovf_stb, .iml_start, .comm_fail_evt, .dsk_seek_err,
        .dsk_read_err, .sense_pending);
    ssf_host_model ssf_host_model_inst (.clk, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("Mismatches %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] w);
        logic ok;
        ssf_host_model_inst.xfer(wr, a, w, d, last_err, ok);
        if (ok !== 1'h1)
        begin
            fail_count++;
            end_sim();
        end
    endtask

    task automatic uc(input logic [7:0] fm);
        @(posedge clk);
        sense_fmt_msg <= fm;
        unit_check <= 1'h1;
        @(posedge clk);
        unit_check <= 1'h0;
    endtask

    task automatic capture(input logic [7:0] fm, input logic [31:0] exp);
        uc(fm);
        bus(1'h0, ssf_pkg::ADDR_SENSE7, 32'h0);
        chk(d, {24'h0, fm});
        bus(1'h0, ssf_pkg::ADDR_SENSE36, 32'h0);
        chk(d, exp);
    endtask

    task automatic seek(input logic rej, input logic [7:0] hi,
                        input logic [7:0] lo, input logic [4:0] hd);
        @(posedge clk);
        {seek_stb, seek_rej, seek_cyl_hi, seek_cyl_lo} <= {1'h1, rej, hi, lo};
        seek_head <= hd;
        @(posedge clk);
        seek_stb <= 1'h0;
    endtask

    task automatic ev(input logic [3:0] v);
        @(posedge clk);
        {iml_start, comm_fail_evt, dsk_seek_err, dsk_read_err} <= v;
        @(posedge clk);
        {iml_start, comm_fail_evt, dsk_seek_err, dsk_read_err} <= 4'h0;
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial
    begin
        rst = 1'h1;
        {unit_check, op_incomplete, op_write, abnormal_end} = 4'h0;
        {exc_prev_ccw, perm_path_err, storage_err, seek_stb} = 4'h0;
        {seek_rej, hs_stb, alt_ovf_stb, iml_start, comm_fail_evt} = 5'h0;
        {dsk_seek_err, dsk_read_err, chain_actuator_right} = 3'h0;
        {actuator_right, seek_service, sense_fmt_msg} = {2'h3, 8'h00};
        {residual_count, controller_id, iar} = 32'h442D_BEEF;
        {device_num, spindle, chain_spindle} = {2'h2, 3'h5, 3'h2};
        {seek_cyl_hi, seek_cyl_lo, seek_head, hs_head} = 26'h0;
        rows[0] = {32'h006B9A00, 8'h00, 4'h8, 32'h06205CF3};
        rows[1] = {32'h006B9A00, 8'h00, 4'hC, 32'h05205CF3};
        rows[2] = {32'h006B9A00, 8'h31, 4'h0, 32'h0020BEEF};
        rows[3] = {32'h006B9A02, 8'hF3, 4'h0, 32'h00005C6B};
        rows[4] = {32'h006B9A02, 8'hF7, 4'h0, 32'h00205CF3};
        rows[5] = {32'h006B9A02, 8'h60, 4'h0, 32'h0000009A};
        rows[6] = {32'h006B9A05, 8'h10, 4'h0, 32'h2D8B5C73};
        rows[7] = {32'h006B9A05, 8'h70, 4'h2, 32'h2DAB5C73};
        rows[8] = {32'h006B9A05, 8'h00, 4'h2, 32'h008B5C73};
        rows[9] = {32'h006B9A02, 8'h38, 4'h0, 32'h00005CF3};
        rows[10] = {32'h006B9A05, 8'h40, 4'h1, 32'h00845C73};
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        bus(1'h0, ssf_pkg::ADDR_CTRL, 32'h0);
        chk(d, ssf_pkg::CTRL_RESET);
        bus(1'h0, ssf_pkg::ADDR_STATUS, 32'h0);
        chk(d | {31'h0, sense_pending}, 32'h0);
        bus(1'h0, 8'h10, 32'h0);
        chk({d[30:0], last_err}, 32'h1);
        seek(1'h0, 8'hA7, 8'h5C, 5'h13);
        for (int i = 0; i < 11; i++)
        begin
            bus(1'h1, ssf_pkg::ADDR_CTRL, rows[i].ctrl);
            {op_incomplete, op_write, perm_path_err, storage_err} <= rows[i].flg;
            capture(rows[i].fm, rows[i].exp);
        end
        {op_incomplete, op_write, perm_path_err, storage_err} <= 4'h0;
        @(posedge clk);
        {abnormal_end, exc_prev_ccw} <= 2'h3;
        @(posedge clk);
        abnormal_end <= 1'h0;
        bus(1'h0, ssf_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, d[ssf_pkg::STAT_IMPREC]}, 32'h1);
        capture(8'h00, 32'h448B5C73);
        bus(1'h1, ssf_pkg::ADDR_CTRL, 32'h006B9A00);
        for (int i = 6; i >= 0; i--)
            ev(4'(28'h8422111 >> (i * 4)));
        capture(8'h60, 32'h0020939A);
        @(posedge clk);
        {hs_stb, hs_head, op_incomplete} <= {1'h1, 5'h0A, 1'h1};
        @(posedge clk);
        hs_stb <= 1'h0;
        seek(1'h1, 8'h00, 8'h11, 5'h01);
        capture(8'h00, 32'h062011EA);
        @(posedge clk);
        alt_ovf_stb <= 1'h1;
        @(posedge clk);
        alt_ovf_stb <= 1'h0;
        capture(8'h00, 32'h062011EB);
        op_incomplete <= 1'h0;
        uc(8'h31);
        iar <= 16'h1234;
        uc(8'h32);
        chk({31'h0, sense_pending}, 32'h1);
        bus(1'h0, ssf_pkg::ADDR_SENSE36, 32'h0);
        chk(d, 32'h0020BEEF);
        end_sim();
    end
endmodule
`default_nettype wire
